// ### rtl/scm_pkg.sv
/*
  scm_pkg: register map, field layout, reset values, timing counts and carrier
  types for the symbol clocking and monitor block.
  Assumes one 100 MHz core clock and an asynchronous active-low reset.
*/
package scm_pkg;

  // register offsets on the microcomputer port
  localparam logic [7:0] SCM_PROBE_SEL_OFS = 8'h01;
  localparam logic [7:0] SCM_MISC_OFS      = 8'h0F;

  // reset values
  localparam logic [7:0] SCM_PROBE_SEL_RST = 8'h00;
  localparam logic [7:0] SCM_MISC_RST      = 8'h00;

  // probe_output_select fields
  localparam int unsigned SCM_SRC_LSB  = 0;
  localparam int unsigned SCM_SRC_W    = 4;
  localparam int unsigned SCM_HCLK_LSB = 6;

  // misc_test_control fields
  localparam int unsigned SCM_REGEN_BIT = 0;
  localparam int unsigned SCM_PAUSE_BIT = 1;
  localparam int unsigned SCM_SYMBOL_CLOCK_OUT_BIT  = 6;
  localparam int unsigned SCM_FULL_BIT  = 7;

  // timing: 128 phase steps per symbol, 8 steps per monitor bit
  localparam int unsigned SCM_CORE_CLK_KHZ  = 100000;
  localparam int unsigned SCM_REF_CLK_KHZ   = 10240;
  localparam int unsigned SCM_BASE_DIV      = 2;
  localparam int unsigned SCM_PHASE_W       = 7;
  localparam int unsigned SCM_WORD_W        = 16;
  localparam int unsigned SCM_SYNC_STAGES   = 3;

  typedef enum logic [1:0] {
    SCM_HCLK_16X = 2'h0,
    SCM_HCLK_32X = 2'h1,
    SCM_HCLK_64X = 2'h2
  } scm_hclk_ratio_t;

  typedef enum logic [1:0] {
    SCM_CU_PAR_MASTER = 2'h0,
    SCM_CU_PAR_SLAVE  = 2'h1,
    SCM_CU_SER_MAG    = 2'h2,
    SCM_CU_SER_SIGN   = 2'h3
  } scm_cu_mode_t;

  typedef enum logic [2:0] {
    SCM_ST_IDLE = 3'b001,
    SCM_ST_RD   = 3'b010,
    SCM_ST_WR   = 3'b100
  } scm_bus_st_t;

  // microcomputer control strobes, all asynchronous pins
  typedef struct packed {
    logic motel;
    logic wr_rw_n;
    logic rd_ds_n;
    logic cs_n;
  } scm_mci_ctl_t;

  // strobes toward the channel unit data path
  typedef struct packed {
    logic tx_sample;
    logic rx_update;
  } scm_cu_stb_t;

endpackage

// ### rtl/scm_top.sv
/*
  scm_top: symbol clock, high-speed clock, baud clock selection, serial probe
  output and the two registers behind the microcomputer port.
  Assumes a 100 MHz core clock; bus strobes, address, data and the baud
  clocks arrive asynchronously; probe words come from core-clock logic.
*/
`timescale 1ns/1ps

module scm_top #(
  parameter int unsigned N_SRC = 16,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic                                   i_core_clk,
  input  wire logic                                   i_rst_n,
  // microcomputer port
  input  wire scm_pkg::scm_mci_ctl_t                  i_mci_ctl,
  input  wire logic [7:0]                             i_addr,
  input  wire logic [7:0]                             i_ad_in,
  output logic      [7:0]                             o_ad_out,
  output logic                                        o_ad_oe,
  output logic                                        o_ready_n_out,
  output logic                                        o_ready_n_oe,
  // clock side
  input  wire logic                                   i_tx_baud_clk_in,
  input  wire logic                                   i_rx_baud_clk_in,
  input  wire logic [1:0]                             i_cu_mode,
  input  wire logic                                   i_baud_edge_rise,
  input  wire logic                                   i_regen_tick,
  input  wire logic                                   i_remote_mode,
  input  wire logic                                   i_rx_phase_adv,
  input  wire logic                                   i_rx_phase_ret,
  output logic                                        o_symbol_clock_out,
  output logic                                        o_hclk_out,
  output scm_pkg::scm_cu_stb_t                        o_cu_stb,
  // probe words
  input  wire logic                                   i_mon_valid,
  input  wire logic [N_SRC-1:0][scm_pkg::SCM_WORD_W-1:0] i_mon_words,
  output logic                                        o_mon_ready,
  output logic                                        o_probe_serial_out
);

  localparam int unsigned SS = scm_pkg::SCM_SYNC_STAGES;
  localparam int unsigned PW = scm_pkg::SCM_PHASE_W;
  localparam int unsigned WW = scm_pkg::SCM_WORD_W;
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // ---------------- input synchronisers ----------------
  // 4 control strobes plus 2 baud clocks, each filtered on stage 2 == stage 3
  logic [5:0]    async_in;
  wire  [5:0]    filt_reg;
  logic [7:0]    addr_pipe_reg [SS];
  logic [7:0]    data_pipe_reg [SS];

  assign async_in = {i_rx_baud_clk_in, i_tx_baud_clk_in, i_mci_ctl};

  genvar g;
  generate
    for (g = 0; g < 6; g++)
    begin : g_sync
      logic [SS-1:0] sh_reg;
      logic          f_reg;
      always_ff @(posedge i_core_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
          sh_reg <= '1;
        else
          sh_reg <= {sh_reg[SS-2:0], async_in[g]};
      end
      always_ff @(posedge i_core_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
          f_reg <= 1'b1;
        else if (sh_reg[1] == sh_reg[2])
          f_reg <= sh_reg[2];
      end
      assign filt_reg[g] = f_reg;
    end
  endgenerate

  // address and data are held stable around a strobe, so a plain pipe suffices
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int i = 0; i < SS; i++)
      begin
        addr_pipe_reg[i] <= 8'h00;
        data_pipe_reg[i] <= 8'h00;
      end
    end
    else
    begin
      addr_pipe_reg[0] <= i_addr;
      data_pipe_reg[0] <= i_ad_in;
      for (int i = 1; i < SS; i++)
      begin
        addr_pipe_reg[i] <= addr_pipe_reg[i-1];
        data_pipe_reg[i] <= data_pipe_reg[i-1];
      end
    end
  end

  scm_pkg::scm_mci_ctl_t ctl;
  logic                  tx_baud;
  logic                  rx_baud;
  assign ctl     = filt_reg[3:0];
  assign tx_baud = filt_reg[4];
  assign rx_baud = filt_reg[5];

  // ---------------- register access ----------------
  logic               rd_act;
  logic               wr_act;
  scm_pkg::scm_bus_st_t st_reg;
  logic [7:0]         probe_sel_reg;
  logic [7:0]         misc_reg;
  logic [7:0]         rd_data;
  logic               fifo_full;
  logic               symbol_clock_out_reg;

  assign rd_act = !ctl.cs_n && (ctl.motel ? (!ctl.rd_ds_n && ctl.wr_rw_n) : !ctl.rd_ds_n);
  assign wr_act = !ctl.cs_n && (ctl.motel ? (!ctl.rd_ds_n && !ctl.wr_rw_n) : !ctl.wr_rw_n);

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      st_reg <= scm_pkg::SCM_ST_IDLE;
    else
    begin
      case (st_reg)
        scm_pkg::SCM_ST_IDLE:
          if (rd_act)
            st_reg <= scm_pkg::SCM_ST_RD;
          else if (wr_act)
            st_reg <= scm_pkg::SCM_ST_WR;
        scm_pkg::SCM_ST_RD:
          if (!rd_act)
            st_reg <= scm_pkg::SCM_ST_IDLE;
        scm_pkg::SCM_ST_WR:
          if (!wr_act)
            st_reg <= scm_pkg::SCM_ST_IDLE;
        default:
          st_reg <= scm_pkg::SCM_ST_IDLE;
      endcase
    end
  end

  // write lands when the strobe goes away, as on the trailing strobe edge
  // reset clears ratio
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      probe_sel_reg <= scm_pkg::SCM_PROBE_SEL_RST;
      misc_reg      <= scm_pkg::SCM_MISC_RST;
    end
    else if (st_reg == scm_pkg::SCM_ST_WR && !wr_act)
    begin
      if (addr_pipe_reg[SS-1] == scm_pkg::SCM_PROBE_SEL_OFS)
        probe_sel_reg <= data_pipe_reg[SS-1];
      if (addr_pipe_reg[SS-1] == scm_pkg::SCM_MISC_OFS)
        misc_reg <= data_pipe_reg[SS-1];
    end
  end

  always_comb
  begin
    rd_data = 8'h00;
    if (addr_pipe_reg[SS-1] == scm_pkg::SCM_PROBE_SEL_OFS)
      rd_data = probe_sel_reg;
    else if (addr_pipe_reg[SS-1] == scm_pkg::SCM_MISC_OFS)
    begin
      rd_data = {2'h0, misc_reg[5:0]};
      rd_data[scm_pkg::SCM_SYMBOL_CLOCK_OUT_BIT] = symbol_clock_out_reg;
      rd_data[scm_pkg::SCM_FULL_BIT] = fifo_full;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_ad_out <= 8'h00;
      o_ad_oe  <= 1'b0;
    end
    else
    begin
      o_ad_out <= rd_data;
      o_ad_oe  <= (st_reg == scm_pkg::SCM_ST_RD) && rd_act;
    end
  end

  // ready is open drain: pulled low while an access is in progress
  assign o_ready_n_out = 1'b0;
  assign o_ready_n_oe  = (st_reg != scm_pkg::SCM_ST_IDLE);

  // ---------------- timing base ----------------
  logic                  regen_en;
  logic [1:0]            ratio;
  logic [$clog2(scm_pkg::SCM_BASE_DIV+1)-1:0] div_reg;
  logic                  base_tick;
  logic [PW-1:0]         phase_reg;
  logic [PW-1:0]         phase_next;
  logic                  word_start;
  logic                  bit_tick;

  assign regen_en = misc_reg[scm_pkg::SCM_REGEN_BIT];
  assign ratio    = probe_sel_reg[scm_pkg::SCM_HCLK_LSB +: 2];

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      div_reg <= '0;
    else if (div_reg == ($bits(div_reg))'(scm_pkg::SCM_BASE_DIV - 1))
      div_reg <= '0;
    else
      div_reg <= div_reg + 1'b1;
  end

  assign base_tick = regen_en ? i_regen_tick : (div_reg == ($bits(div_reg))'(scm_pkg::SCM_BASE_DIV - 1));

  always_comb
  begin
    phase_next = phase_reg;
    if (base_tick)
    begin
      if (i_remote_mode && i_rx_phase_adv)
        phase_next = phase_reg + PW'(2);
      else if (!(i_remote_mode && i_rx_phase_ret))
        phase_next = phase_reg + PW'(1);
    end
  end

  // msb falling marks the wrap, robust to a skipped step
  assign word_start = phase_reg[PW-1] && !phase_next[PW-1];
  assign bit_tick   = phase_reg[3] != phase_next[3];

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      phase_reg <= '0;
    else
      phase_reg <= phase_next;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      symbol_clock_out_reg <= 1'b1;
    else
      symbol_clock_out_reg <= !phase_next[PW-1];
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_hclk_out <= 1'b1;
    // ratio change waits for a phase step, so no sliver pulse
    else if (base_tick)
    begin
      case (ratio)
        scm_pkg::SCM_HCLK_32X: o_hclk_out <= !phase_next[1];
        scm_pkg::SCM_HCLK_64X: o_hclk_out <= !phase_next[0];
        default:               o_hclk_out <= !phase_next[2];
      endcase
    end
  end

  assign o_symbol_clock_out = symbol_clock_out_reg;

  // ---------------- channel unit strobes ----------------
  logic tx_baud_d_reg;
  logic rx_baud_d_reg;
  logic slave;

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tx_baud_d_reg <= 1'b1;
      rx_baud_d_reg <= 1'b1;
    end
    else
    begin
      tx_baud_d_reg <= tx_baud;
      rx_baud_d_reg <= rx_baud;
    end
  end

  assign slave = (i_cu_mode == scm_pkg::SCM_CU_PAR_SLAVE);

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_cu_stb <= '0;
    else if (slave)
    begin
      o_cu_stb.tx_sample <= i_baud_edge_rise ? (tx_baud && !tx_baud_d_reg) : (!tx_baud && tx_baud_d_reg);
      o_cu_stb.rx_update <= i_baud_edge_rise ? (rx_baud && !rx_baud_d_reg) : (!rx_baud && rx_baud_d_reg);
    end
    else
    begin
      o_cu_stb.tx_sample <= !phase_reg[PW-1] && phase_next[PW-1];
      o_cu_stb.rx_update <= word_start;
    end
  end

  // ---------------- probe buffer ----------------
  localparam int unsigned SCM_SRC_WL = scm_pkg::SCM_SRC_W;

  logic [WW-1:0]            mem [DEPTH];
  logic [AW-1:0]            wptr_reg;
  logic [AW-1:0]            rptr_reg;
  logic [$clog2(DEPTH+1)-1:0] cnt_reg;
  logic [SCM_SRC_WL-1:0]    sel_act_reg;
  logic                     push;
  logic                     pop;
  logic [WW-1:0]            word_reg;

  // pause lets software stall the drain, so the buffer backs up to the source
  assign fifo_full   = (cnt_reg == ($bits(cnt_reg))'(DEPTH));
  assign o_mon_ready = !fifo_full;
  assign push        = i_mon_valid && !fifo_full;
  assign pop         = word_start && !misc_reg[scm_pkg::SCM_PAUSE_BIT] && (cnt_reg != '0);

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      sel_act_reg <= '0;
    else if (word_start)
      sel_act_reg <= probe_sel_reg[scm_pkg::SCM_SRC_LSB +: SCM_SRC_WL];
  end

  always_ff @(posedge i_core_clk)
  begin
    if (push)
      mem[wptr_reg] <= i_mon_words[sel_act_reg];
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg  <= '0;
    end
    else
    begin
      if (push)
        wptr_reg <= (wptr_reg == AW'(DEPTH - 1)) ? '0 : wptr_reg + 1'b1;
      if (pop)
        rptr_reg <= (rptr_reg == AW'(DEPTH - 1)) ? '0 : rptr_reg + 1'b1;
      if (push && !pop)
        cnt_reg <= cnt_reg + 1'b1;
      else if (pop && !push)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // an empty or paused slot sends an all-zero word
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      word_reg <= '0;
    else if (word_start)
      word_reg <= pop ? mem[rptr_reg] : '0;
  end

  // ---------------- serial probe output ----------------
  // word starts with LSB
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_probe_serial_out <= 1'b0;
    else if (word_start)
      o_probe_serial_out <= pop ? mem[rptr_reg][0] : 1'b0;
    else if (bit_tick)
      o_probe_serial_out <= word_reg[phase_next[PW-1:3]];
  end

endmodule // scm_top

// ### test/scm_feed_model.sv
/*
  scm_feed_model: far-side framer and probe word source for scm_top.
  Assumes the core clock; drives valid and baud clocks on the falling edge; the word sequence advances on the rising edge.
*/
`timescale 1ns/1ps

module scm_feed_model #(
  parameter int unsigned N_SRC = 16
) (
  input  wire logic                                  i_clk,
  input  wire logic                                  i_rst_n,
  input  wire logic                                  i_slow,
  input  wire logic                                  i_baud_en,
  input  wire logic                                  i_symbol_clock,
  input  wire logic                                  i_mon_ready,
  output logic                                       o_mon_valid = 1'b0,
  output logic [N_SRC-1:0][scm_pkg::SCM_WORD_W-1:0] o_mon_words,
  output logic                                       o_tx_baud,
  output logic                                       o_rx_baud
);
  logic [11:0] seq   = 12'h000;
  logic        taken = 1'b0;
  logic [7:0]  dly   = 8'h00;

  always @(posedge i_clk)
  begin
    taken = i_rst_n && o_mon_valid && i_mon_ready;
    if (taken)
      seq <= seq + 12'h001;
  end

  always @(negedge i_clk)
  begin
    dly <= {dly[6:0], i_symbol_clock};
    if (taken || !o_mon_valid)
      o_mon_valid <= !i_slow || ($urandom_range(2) == 0);
    taken = 1'b0;
  end

  assign o_tx_baud = i_baud_en & dly[2];
  assign o_rx_baud = i_baud_en & dly[6];

  // idle words are inverted so stale data never passes
  for (genvar s = 0; s < N_SRC; s++)
  begin : g_word
    assign o_mon_words[s] = {4'(s), seq} ^ {16{!o_mon_valid}};
  end
endmodule // scm_feed_model

// ### test/scm_top_properties.sv
/*
  scm_top_properties: timing checks on clock, probe and bus ports of scm_top.
  Assumes the default symbol of 256 core cycles and one clock domain.
*/
`timescale 1ns/1ps

module scm_top_properties (
  input wire logic                 i_core_clk,
  input wire logic                 i_rst_n,
  input wire logic [1:0]           i_cu_mode,
  input wire logic                 i_regen_tick,
  input wire logic                 i_remote_mode,
  input wire logic                 o_ad_oe,
  input wire logic                 o_ready_n_oe,
  input wire logic                 o_symbol_clock_out,
  input wire logic                 o_hclk_out,
  input wire scm_pkg::scm_cu_stb_t o_cu_stb,
  input wire logic                 o_mon_ready,
  input wire logic                 o_probe_serial_out
);
  logic       sym_q_reg;
  logic       quiet_reg;
  logic [7:0] cnt_reg;
  logic       rise;
  logic       fall;
  logic       lock_off;

  assign rise = o_symbol_clock_out & ~sym_q_reg;
  assign fall = ~o_symbol_clock_out & sym_q_reg;
  // ticks and phase steps bend the period, so period checks pause
  assign lock_off = ~(i_regen_tick | i_remote_mode);

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sym_q_reg <= 1'b1;
      quiet_reg <= 1'b0;
      cnt_reg   <= 8'h00;
    end
    else
    begin
      sym_q_reg <= o_symbol_clock_out;
      quiet_reg <= (rise | quiet_reg) & lock_off;
      cnt_reg   <= rise ? 8'h01 : cnt_reg + 8'h01;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  AST_SYM_PERIOD: assert property (rise && quiet_reg |-> cnt_reg == 8'h00)
    else $error("symbol period is not 256 cycles");
  AST_SYM_HALF: assert property (fall && quiet_reg |-> cnt_reg == 8'h80)
    else $error("symbol clock high time is not 128 cycles");
  AST_HCLK_ALIGN: assert property (rise |-> $rose(o_hclk_out))
    else $error("high-speed clock not rising with symbol clock");
  AST_HCLK_EDGE: assert property ($changed(o_hclk_out) && quiet_reg |-> !cnt_reg[0])
    else $error("high-speed clock edge off the phase grid");
  AST_PROBE_TICK: assert property ($changed(o_probe_serial_out) && quiet_reg |-> cnt_reg[3:0] == 4'h0)
    else $error("probe bit changed off the 16x tick");
  AST_READ_DRIVE: assert property ($rose(o_ad_oe) |-> o_ready_n_oe && $past(o_ready_n_oe))
    else $error("read data driven outside an access");
  AST_READ_RELEASE: assert property ($fell(o_ready_n_oe) |=> !o_ad_oe)
    else $error("read data still driven after access end");
  AST_RX_OWN: assert property (o_cu_stb.rx_update && i_cu_mode != 2'h1 && $past(i_cu_mode, 8) != 2'h1
    |-> o_symbol_clock_out)
    else $error("receive update not on symbol clock rise");
  AST_TX_OWN: assert property (o_cu_stb.tx_sample && i_cu_mode != 2'h1 && $past(i_cu_mode, 8) != 2'h1
    |-> !o_symbol_clock_out)
    else $error("transmit sample not on symbol clock fall");

  COV_WORD: cover property (rise && quiet_reg);
  COV_READ: cover property ($rose(o_ad_oe));
  COV_FULL: cover property (!o_mon_ready);
endmodule // scm_top_properties

bind scm_top scm_top_properties scm_top_properties_inst (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_cu_mode(i_cu_mode), .i_regen_tick(i_regen_tick),
  .i_remote_mode(i_remote_mode), .o_ad_oe(o_ad_oe), .o_ready_n_oe(o_ready_n_oe),
  .o_symbol_clock_out(o_symbol_clock_out), .o_hclk_out(o_hclk_out), .o_cu_stb(o_cu_stb),
  .o_mon_ready(o_mon_ready), .o_probe_serial_out(o_probe_serial_out));

// ### test/scm_top_tb.sv
/*
  scm_top_tb: self-checking bench for scm_top with the feed model at its far side.
  Assumes default parameters: 256-cycle symbol, 16 probe sources.
*/
`timescale 1ns/1ps

module scm_top_tb;
  logic                  i_core_clk = 1'b0;
  logic                  i_rst_n = 1'b0;
  scm_pkg::scm_mci_ctl_t i_mci_ctl = 4'hF;
  logic [7:0]            i_addr = 8'h00;
  logic [7:0]            i_ad_in = 8'h00;
  logic [1:0]            i_cu_mode = 2'h0;
  logic                  i_baud_edge_rise = 1'b1;
  logic                  i_regen_tick = 1'b0;
  logic                  i_remote_mode = 1'b0;
  logic                  i_rx_phase_adv = 1'b0;
  logic                  i_rx_phase_ret = 1'b0;
  logic                  slow = 1'b0;
  logic                  baud_en = 1'b1;
  logic                  psel = 1'b0;
  logic [7:0]            o_ad_out;
  logic                  o_ad_oe, o_ready_n_out, o_ready_n_oe, o_symbol_clock_out, o_hclk_out;
  logic                  o_mon_ready, o_probe_serial_out, i_mon_valid;
  logic                  i_tx_baud_clk_in, i_rx_baud_clk_in;
  scm_pkg::scm_cu_stb_t  o_cu_stb;
  logic [15:0][15:0]     i_mon_words;
  int                    errors = 0;
  int                    n_checks = 0;
  int                    r;
  time                   t0;
  logic [3:0]            s;
  logic [15:0]           w1;
  logic [15:0]           w2;
  wire                   mx = psel ? o_symbol_clock_out : o_hclk_out;

  always #5 i_core_clk = ~i_core_clk;

  scm_top scm_top_inst (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_mci_ctl(i_mci_ctl), .i_addr(i_addr), .i_ad_in(i_ad_in),
    .o_ad_out(o_ad_out), .o_ad_oe(o_ad_oe), .o_ready_n_out(o_ready_n_out), .o_ready_n_oe(o_ready_n_oe),
    .i_tx_baud_clk_in(i_tx_baud_clk_in), .i_rx_baud_clk_in(i_rx_baud_clk_in), .i_cu_mode(i_cu_mode),
    .i_baud_edge_rise(i_baud_edge_rise), .i_regen_tick(i_regen_tick), .i_remote_mode(i_remote_mode),
    .i_rx_phase_adv(i_rx_phase_adv), .i_rx_phase_ret(i_rx_phase_ret), .o_symbol_clock_out(o_symbol_clock_out),
    .o_hclk_out(o_hclk_out), .o_cu_stb(o_cu_stb), .i_mon_valid(i_mon_valid), .i_mon_words(i_mon_words),
    .o_mon_ready(o_mon_ready), .o_probe_serial_out(o_probe_serial_out));

  scm_feed_model scm_feed_model_inst (
    .i_clk(i_core_clk), .i_rst_n(i_rst_n), .i_slow(slow), .i_baud_en(baud_en),
    .i_symbol_clock(o_symbol_clock_out), .i_mon_ready(o_mon_ready), .o_mon_valid(i_mon_valid),
    .o_mon_words(i_mon_words), .o_tx_baud(i_tx_baud_clk_in), .o_rx_baud(i_rx_baud_clk_in));

  function automatic int hclk_per(input int code);
    return (code == 1) ? 8 : (code == 2) ? 4 : 16;
  endfunction

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // random convention per access; strobes held well past the filter delay
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    logic m;
    m = 1'($urandom);
    @(negedge i_core_clk);
    i_addr = a;
    i_ad_in = d;
    i_mci_ctl = {m, !w, 1'b1, 1'b1};
    @(negedge i_core_clk);
    i_mci_ctl = {m, !w, !(m || !w), 1'b0};
    repeat (12) @(negedge i_core_clk);
    q = o_ad_out;
    if (!w) chk("read_oe", 16'h0001, {15'h0, o_ad_oe});
    chk("ready_oe", 16'h0002, {14'h0, o_ready_n_oe, o_ready_n_out});
    i_mci_ctl = {m, !w, 1'b1, 1'b1};
    repeat (8) @(negedge i_core_clk);
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask

  task rchk(input string nm, input logic [7:0] a, input logic [7:0] e, input logic [7:0] mk);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(nm, {8'h0, e}, {8'h0, q & mk});
  endtask

  // first edge after a select change may close a mixed period
  task per(input logic sel, input int e, input logic [1:0] kick, input string nm);
    psel = sel;
    @(posedge mx);
    @(posedge mx);
    t0 = $time;
    // a kick only fits inside the long symbol period
    if (kick != 2'b00)
    begin
      repeat (20) @(negedge i_core_clk);
      {i_rx_phase_adv, i_rx_phase_ret} = kick;
      repeat (2) @(negedge i_core_clk);
      {i_rx_phase_adv, i_rx_phase_ret} = 2'b00;
    end
    @(posedge mx);
    chk(nm, e[15:0], 16'(($time - t0) / 10));
  endtask

  task get_word(output logic [15:0] w);
    @(posedge o_symbol_clock_out);
    for (int i = 0; i < 16; i++)
    begin
      repeat (8) @(negedge i_core_clk);
      w[i] = o_probe_serial_out;
      repeat (8) @(negedge i_core_clk);
    end
  endtask

  task pair(input string nm, input logic [3:0] src);
    get_word(w1);
    get_word(w2);
    chk(nm, {src, w1[11:0] + 12'h001}, w2);
  endtask

  task stb(input logic [1:0] md, input logic en, input int e, input string nm);
    int n;
    i_cu_mode = md;
    baud_en = en;
    i_baud_edge_rise = 1'($urandom);
    repeat (300) @(negedge i_core_clk);
    n = 0;
    repeat (1024)
    begin
      @(negedge i_core_clk);
      n += o_cu_stb.rx_update + o_cu_stb.tx_sample;
    end
    chk(nm, e[15:0], n[15:0]);
  endtask

  task end_of_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    #800_000;
    errors++;
    end_of_test;
  end

  initial
  begin
    void'($urandom(32'h74a3b492));
    repeat (6) @(negedge i_core_clk);
    i_rst_n = 1'b1;
    rchk("sel_rst", 8'h01, 8'h00, 8'hFF);
    rchk("misc_rst", 8'h0F, 8'h00, 8'h3F);
    rchk("unmapped", 8'h05, 8'h00, 8'hFF);
    per(1'b1, 256, 2'b00, "sym_per");
    per(1'b0, 16, 2'b00, "hclk_rst");
    for (r = 0; r < 4; r++)
    begin
      wr(8'h01, {r[1:0], 6'h00});
      rchk("sel_rw", 8'h01, {r[1:0], 6'h00}, 8'hFF);
      per(1'b0, hclk_per(r), 2'b00, "hclk_ratio");
    end
    wr(8'h01, 8'h80);
    i_rst_n = 1'b0;
    repeat (2) @(negedge i_core_clk);
    i_rst_n = 1'b1;
    rchk("sel_rst2", 8'h01, 8'h00, 8'hFF);
    per(1'b0, 16, 2'b00, "hclk_rst2");
    repeat (4)
    begin
      s = 4'($urandom);
      slow = 1'($urandom);
      wr(8'h01, {4'h0, s});
      repeat (3) @(posedge o_symbol_clock_out);
      pair("word", s);
    end
    slow = 1'b0;
    wr(8'h0F, 8'h02);
    repeat (3) @(posedge o_symbol_clock_out);
    @(negedge i_core_clk);
    chk("full_ready", 16'h0000, {15'h0, o_mon_ready});
    rchk("full_flag", 8'h0F, 8'h82, 8'hBF);
    get_word(w1);
    chk("paused", 16'h0000, w1);
    wr(8'h0F, 8'h00);
    pair("drain", s);
    for (r = 0; r < 4; r++)
      stb(r[1:0], 1'b0, (r == 1) ? 0 : 8, "stb_mode");
    stb(2'h1, 1'b1, 8, "stb_slave");
    i_remote_mode = 1'b1;
    per(1'b1, 254, 2'b10, "remote_adv");
    per(1'b1, 258, 2'b01, "remote_ret");
    @(negedge i_core_clk);
    i_remote_mode = 1'b0;
    i_regen_tick = 1'b1;
    per(1'b1, 256, 2'b00, "regen_off");
    wr(8'h0F, 8'h01);
    rchk("misc_rw", 8'h0F, 8'h01, 8'h3F);
    per(1'b1, 128, 2'b00, "regen_sym");
    per(1'b0, 8, 2'b00, "regen_hclk");
    wr(8'h0F, 8'h00);
    i_regen_tick = 1'b0;
    per(1'b1, 256, 2'b00, "regen_clr");
    end_of_test;
  end
endmodule // scm_top_tb
